// File: hw/aotc_ctrl.sv
// What this block does
// R01 - irq pin open-drain, pulls low when active
// R02 - pin control bit 2 picks irq pin role
// R03 - pin control bit 1 drives aux pin
// R04 - bit 0 drives irq pin in output role
// R05 - 8-bit flow variable, resets to zero
// R06 - writing all ones resets every register
// R07 - soft reset register always reads 03
// R08 - thermal bit 7 shows conversion busy
// R09 - writing enable 1 starts a conversion
// R10 - busy stands for whole conversion period
// R11 - result lands in register 3F
// R12 - repeat bit selects continuous conversions
// R13 - repeat only acts with enable set
// R14 - thermal bit 0 picks compensation source
// R15 - status read releases irq pin
// R16 - result is signed degrees celsius
// R17 - other soft reset writes ignored
// R18 - enable during conversion restarts period
`timescale 1ns/1ps
`default_nettype none
module aotc_ctrl
    import aotc_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES   // cycles per conversion
) (
    // clock, reset, enable
    input  wire  logic       clock_i,
    input  wire  logic       rstn_i,
    input  wire  logic       ce_i,
    // register access port
    input  wire  logic [7:0] reg_addr_i,
    input  wire  logic [7:0] reg_wdata_i,
    input  wire  logic       reg_wr_i,
    input  wire  logic       reg_rd_i,
    output logic       [7:0] reg_rdata_o,
    // interrupt source and device state
    input  wire  logic       irq_event_i,
    input  wire  logic       power_save_i,
    // temperature sensor
    input  wire  logic [7:0] sensor_value_i,
    output logic             sensor_enable_o,
    // pins
    output logic             aux_output_pin_o,
    output logic             irq_pin_o,
    output logic             irq_pin_oe_o,
    // values for the rest of the device
    output logic       [7:0] program_flow_variable_o,
    output logic signed [7:0] compensation_temp_o,
    output logic             soft_reset_o
);

    // ---------------------------------------------------------------
    // notes
    // ---------------------------------------------------------------
    // the period counter runs on the system clock, so a period has a
    // fixed length; a real sensor period drifts with temperature
    // the sensor sample is taken once, on the last cycle of a period
    // a write of enable 0 aborts the period and keeps the old result
    // an irq event in the same cycle as a status read wins, so the
    // pin stays pulled and no event is lost
    // soft reset acts one cycle after the key write so that the write
    // itself completes; anything written during the pulse is lost
    // the reset input ignores the clock enable, so a frozen block can
    // still be brought back to its defaults
    // pin levels and the compensation value come straight from flops

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    // counter constants at the counter's own width
    localparam int CW = $clog2(CONV_CNT + 1);     // counter width
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(CONV_CNT);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,                      // no conversion
        ST_CONVERT,                   // conversion running
        ST_WAIT_PS                    // one-shot or paused repeat, waiting power save exit
    } aotc_conv_t;

    // every register of the block in one word
    typedef struct packed {
        logic       irq_role_select;            // 1: irq pin is output
        logic       aux_output_pin;             // aux pin level
        logic       irq_pin_drive_level;        // irq pin level as output
        logic [7:0] flow_var;                   // program flow variable
        logic       sensor_en;                  // sensor enable bit
        logic       repeat_conversion_select;   // continuous mode
        logic       compensation_source_select; // 1: external value
        aotc_conv_t conv;                       // conversion state
        logic [CW-1:0] cnt;                     // cycles left in period
        logic [7:0] t_result;                   // internal result
        logic [7:0] t_ext;                      // host-written value
        logic       irq_pend;                   // irq pin pulled low
        logic       ps_last;                    // power save last cycle
        logic [7:0] rdata;                      // read data
        logic       soft_rst;                   // soft reset pulse
        logic       irq_pin;                    // irq pin data
        logic       irq_pin_oe;                 // irq pin driven
        logic [7:0] comp_temp;                  // compensation value
    } aotc_state_t;

    aotc_state_t r;        // registered state
    aotc_state_t next_r;   // next state

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // reset value of the whole state
    function automatic aotc_state_t rst_state();
        aotc_state_t s;
        s                            = '0;
        s.flow_var                   = RST_FLOW_VAR;
        s.conv                       = ST_IDLE;
        s.cnt                        = CNT_ZERO;
        s.t_result                   = RST_T_RESULT;
        s.t_ext                      = RST_T_EXT;
        s.rdata                      = READ_ZERO;
        // pin released, compensation on the internal result
        s.comp_temp                  = RST_T_RESULT;
        return s;
    endfunction : rst_state

    // register read multiplexer
    // status and unmapped offsets read as zero here
    function automatic logic [7:0] read_mux(input aotc_state_t s,
                                            input logic [7:0] a);
        logic [7:0] d;
        d = READ_ZERO;
        unique case (a)
            OFS_PIN_CTRL: begin
                d[BIT_ROLE_SEL]  = s.irq_role_select;
                d[BIT_AUX_LEVEL] = s.aux_output_pin;
                d[BIT_IRQ_LEVEL] = s.irq_pin_drive_level;
            end
            OFS_FLOW_VAR: d = s.flow_var;
            OFS_SOFT_RST: d = SOFT_RST_READ;            // see R07
            OFS_THERM: begin
                d[BIT_BUSY]     = (s.conv == ST_CONVERT); // see R08
                d[BIT_SENS_EN]  = s.sensor_en;
                d[BIT_REPEAT]   = s.repeat_conversion_select;
                d[BIT_COMP_SEL] = s.compensation_source_select;
            end
            OFS_T_RESULT: d = s.t_result;               // see R11
            OFS_T_EXT:    d = s.t_ext;
            default:      d = READ_ZERO;                // unmapped
        endcase
        return d;
    endfunction : read_mux

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    // strobes and events of this cycle
    logic wr_hit;       // write strobe
    logic start_conv;   // host launch of a conversion
    logic ps_exit;      // power save just left

    always_comb begin
        next_r          = r;
        next_r.soft_rst = 1'b0;
        wr_hit          = reg_wr_i;
        start_conv      = 1'b0;
        // power save exit, seen in the first cycle the input is low
        ps_exit         = r.ps_last && !power_save_i;
        next_r.ps_last  = power_save_i;

        // interrupt pin latch: new event wins over status read
        if (irq_event_i) begin
            next_r.irq_pend = 1'b1;
        end else if (reg_rd_i && reg_addr_i == OFS_STATUS) begin
            next_r.irq_pend = 1'b0;                      // see R15
        end

        // read data captured from current state
        if (reg_rd_i) begin
            next_r.rdata = read_mux(r, reg_addr_i);
        end

        // conversion sequencing
        unique case (r.conv)
            ST_IDLE: begin
                // nothing running
                // only a host enable write leaves this state
            end
            ST_CONVERT: begin
                // last cycle of the period: sample the sensor
                if (r.cnt == CNT_ONE) begin              // see R10
                    next_r.t_result = sensor_value_i;    // see R11, R16
                    if (r.repeat_conversion_select
                        && r.sensor_en) begin            // see R13
                        if (power_save_i) begin
                            next_r.conv = ST_WAIT_PS;    // see R12
                        end else begin
                            next_r.cnt  = CNT_LOAD;      // see R12
                        end
                    end else if (r.sensor_en) begin
                        // one-shot: park until power save ends
                        next_r.conv = ST_WAIT_PS;        // see R12
                        next_r.cnt  = CNT_ZERO;
                    end else begin
                        next_r.conv = ST_IDLE;
                        next_r.cnt  = CNT_ZERO;
                    end
                // power save suspends a repeating period
                end else if (power_save_i
                             && r.repeat_conversion_select) begin
                    next_r.conv = ST_WAIT_PS;            // see R12
                    next_r.cnt  = CNT_ZERO;
                end else begin
                    next_r.cnt = r.cnt - CNT_ONE;
                end
            end
            ST_WAIT_PS: begin
                // leaving power save starts the next period
                if (!r.sensor_en) begin
                    next_r.conv = ST_IDLE;
                end else if (ps_exit || (!power_save_i
                             && r.repeat_conversion_select)) begin
                    next_r.conv = ST_CONVERT;            // see R12
                    next_r.cnt  = CNT_LOAD;
                end
            end
            default: begin
                // illegal code: fall back to idle
                next_r.conv = ST_IDLE;
                next_r.cnt  = CNT_ZERO;
            end
        endcase

        // host writes
        if (wr_hit) begin
            unique case (reg_addr_i)
                OFS_PIN_CTRL: begin
                    next_r.irq_role_select =
                        reg_wdata_i[BIT_ROLE_SEL];       // see R02
                    next_r.aux_output_pin =
                        reg_wdata_i[BIT_AUX_LEVEL];      // see R03
                    next_r.irq_pin_drive_level =
                        reg_wdata_i[BIT_IRQ_LEVEL];      // see R04
                end
                OFS_FLOW_VAR: begin
                    next_r.flow_var = reg_wdata_i;       // see R05
                end
                OFS_SOFT_RST: begin
                    // only the key pattern acts
                    if (reg_wdata_i == SOFT_RST_KEY) begin // see R17
                        next_r.soft_rst = 1'b1;          // see R06
                    end
                end
                OFS_THERM: begin
                    // busy bit is read-only and not stored
                    next_r.sensor_en = reg_wdata_i[BIT_SENS_EN];
                    next_r.repeat_conversion_select =
                        reg_wdata_i[BIT_REPEAT];         // see R12
                    next_r.compensation_source_select =
                        reg_wdata_i[BIT_COMP_SEL];       // see R14
                    if (reg_wdata_i[BIT_SENS_EN]) begin
                        start_conv = 1'b1;               // see R09
                    end else begin
                        next_r.conv = ST_IDLE;           // see R09
                        next_r.cnt  = CNT_ZERO;
                    end
                end
                OFS_T_EXT: begin
                    // host value for the external source
                    next_r.t_ext = reg_wdata_i;
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        // every enable write launches a fresh full period
        // after the write decode, so a restart wins over the sequencer
        if (start_conv) begin
            next_r.conv = ST_CONVERT;                    // see R09, R18
            next_r.cnt  = CNT_LOAD;                      // see R18
        end

        // soft reset returns every register to default
        // last in the process so nothing else survives it
        if (r.soft_rst) begin
            next_r          = rst_state();               // see R06
            next_r.ps_last  = power_save_i;
        end

        // pin drive and compensation value, registered with the rest
        if (next_r.irq_role_select) begin                // see R02
            next_r.irq_pin    = next_r.irq_pin_drive_level; // see R04
            next_r.irq_pin_oe = 1'b1;                    // push-pull drive
        end else begin
            // open-drain: data stays low, enable pulls the pin
            next_r.irq_pin    = 1'b0;                    // see R01
            next_r.irq_pin_oe = next_r.irq_pend;         // see R01, R15
        end
        next_r.comp_temp = next_r.compensation_source_select
                         ? next_r.t_ext                  // see R14
                         : next_r.t_result;              // see R14
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // single clocked process, frozen while enable low
    // reset does not wait for the enable
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            r <= rst_state();
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // register read data
    assign reg_rdata_o = r.rdata;

    // aux pin is push-pull, always driven
    assign aux_output_pin_o = r.aux_output_pin;          // see R03

    // irq pin: output role drives level, else open-drain low
    assign irq_pin_o    = r.irq_pin;                     // see R01, R04
    assign irq_pin_oe_o = r.irq_pin_oe;                  // see R02, R15

    // sensor powered while enabled
    assign sensor_enable_o = r.sensor_en;

    // flow variable seen by the program engines
    assign program_flow_variable_o = r.flow_var;         // see R05

    // compensation source select
    assign compensation_temp_o = r.comp_temp;            // see R14

    // soft reset pulse to the rest of the device
    assign soft_reset_o = r.soft_rst;                    // see R06

endmodule : aotc_ctrl
`default_nettype wire

// File: hw/aotc_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// register map, field positions and reset values
// ---------------------------------------------------------------
package aotc_pkg;
    // register offsets
    localparam logic [7:0] OFS_STATUS   = 8'h3A;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h3B;
    localparam logic [7:0] OFS_FLOW_VAR = 8'h3C;
    localparam logic [7:0] OFS_SOFT_RST = 8'h3D;
    localparam logic [7:0] OFS_THERM    = 8'h3E;
    localparam logic [7:0] OFS_T_RESULT = 8'h3F;
    localparam logic [7:0] OFS_T_EXT    = 8'h40;
    // pin control fields
    localparam int BIT_ROLE_SEL  = 2;
    localparam int BIT_AUX_LEVEL = 1;
    localparam int BIT_IRQ_LEVEL = 0;
    // thermal control fields
    localparam int BIT_BUSY      = 7;
    localparam int BIT_SENS_EN   = 2;
    localparam int BIT_REPEAT    = 1;
    localparam int BIT_COMP_SEL  = 0;
    // reset values and magic patterns
    localparam logic [7:0] RST_FLOW_VAR  = 8'h00;
    localparam logic [7:0] RST_T_RESULT  = 8'h19;
    localparam logic [7:0] RST_T_EXT     = 8'h00;
    localparam logic [7:0] SOFT_RST_KEY  = 8'hFF;
    localparam logic [7:0] SOFT_RST_READ = 8'h03;
    localparam logic [7:0] READ_ZERO     = 8'h00;
    // conversion time
    localparam int CLK_HZ        = 10_000_000;
    localparam int CONV_TIME_MS  = 20;
    localparam int CONV_CYCLES   = CONV_TIME_MS * (CLK_HZ / 1000);
endpackage : aotc_pkg
`default_nettype wire

// File: bench/aotc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker for the control block
// ----------------------------------------------------------------
module aotc_monitor
    import aotc_pkg::*;
#(
    parameter int CONV_CNT = 20  // cycles per conversion
) (
    // clock, reset, enable
    input wire logic        clock_i,
    input wire logic        rstn_i,
    input wire logic        ce_i,
    // register access port
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    // device state and sensor
    input wire logic        irq_event_i,
    input wire logic        power_save_i,
    input wire logic [7:0]  sensor_value_i,
    input wire logic        sensor_enable_o,
    // pins and values
    input wire logic        aux_output_pin_o,
    input wire logic        irq_pin_o,
    input wire logic        irq_pin_oe_o,
    input wire logic [7:0]  program_flow_variable_o,
    input wire logic signed [7:0] compensation_temp_o,
    input wire logic        soft_reset_o
);
    // accepted strobes, lost during a soft reset pulse
    wire logic wr_ok = ce_i && reg_wr_i && !soft_reset_o;
    wire logic rd_ok = ce_i && reg_rd_i && !soft_reset_o;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    AST_AUX_LEVEL: assert property (
        wr_ok && reg_addr_i == OFS_PIN_CTRL
        |=> aux_output_pin_o == $past(reg_wdata_i[1]))
        else $error("aux pin differs from written level");
    AST_ROLE_OUTPUT: assert property (
        wr_ok && reg_addr_i == OFS_PIN_CTRL && reg_wdata_i[2]
        |=> irq_pin_oe_o && irq_pin_o == $past(reg_wdata_i[0]))
        else $error("irq pin not driven at written level");
    AST_PIN_RELEASED: assert property (
        !irq_pin_oe_o |-> !irq_pin_o)
        else $error("irq pin data high while released");
    AST_IRQ_PULL: assert property (
        ce_i && irq_event_i && !soft_reset_o |=> irq_pin_oe_o)
        else $error("irq pin not pulled after event");
    AST_FLOW_VAR: assert property (
        wr_ok && reg_addr_i == OFS_FLOW_VAR
        |=> program_flow_variable_o == $past(reg_wdata_i))
        else $error("flow variable not updated");
    AST_SOFT_RESET: assert property (
        wr_ok && reg_addr_i == OFS_SOFT_RST && reg_wdata_i == SOFT_RST_KEY
        |=> soft_reset_o ##1 (program_flow_variable_o == RST_FLOW_VAR
        && !sensor_enable_o && !aux_output_pin_o))
        else $error("soft reset did not restore defaults");
    AST_SOFT_IGNORE: assert property (
        wr_ok && reg_addr_i == OFS_SOFT_RST && reg_wdata_i != SOFT_RST_KEY
        |=> !soft_reset_o)
        else $error("soft reset fired on wrong pattern");
    AST_RESET_READ: assert property (
        rd_ok && reg_addr_i == OFS_SOFT_RST |=> reg_rdata_o == SOFT_RST_READ)
        else $error("soft reset register read wrong");
    AST_SENSOR_EN: assert property (
        wr_ok && reg_addr_i == OFS_THERM
        |=> sensor_enable_o == $past(reg_wdata_i[2]))
        else $error("sensor enable differs from written bit");
endmodule : aotc_monitor
bind aotc_ctrl aotc_monitor #(.CONV_CNT(CONV_CNT)) u_mon (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_event_i(irq_event_i), .power_save_i(power_save_i),
    .sensor_value_i(sensor_value_i), .sensor_enable_o(sensor_enable_o),
    .aux_output_pin_o(aux_output_pin_o), .irq_pin_o(irq_pin_o),
    .irq_pin_oe_o(irq_pin_oe_o),
    .program_flow_variable_o(program_flow_variable_o),
    .compensation_temp_o(compensation_temp_o),
    .soft_reset_o(soft_reset_o));
`default_nettype wire

// File: bench/aotc_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// temperature sensor at the far side
// ----------------------------------------------------------------
module aotc_sensor_model (
    // clock and control
    input  wire logic       clock_i,
    input  wire logic       enable_i,
    input  wire logic [7:0] level_i,
    // sample towards the block
    output logic      [7:0] value_o
);
    // known start value before the first edge
    initial value_o = 8'h5A;
    // powered sensor holds the level, idle one toggles each cycle
    always @(posedge clock_i) begin
        value_o <= enable_i ? level_i : ~value_o;
    end
endmodule : aotc_sensor_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aotc_pkg::*;
    logic       clock_i = 1'h0, rstn_i = 1'h0, ce_i = 1'h1;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, lvl = 8'h00;
    logic       reg_wr_i = 1'h0, reg_rd_i = 1'h0;
    logic       irq_event_i = 1'h0, power_save_i = 1'h0;
    logic [7:0] reg_rdata_o, sensor_value_i, flow_o, q, v;
    logic       sensor_enable_o, aux_o, irq_o, oe_o, srst_o;
    logic signed [7:0] comp_o;
    int         n_errors = 0, tests_run = 0, cycles = 0;
    // reset-value table, unmapped offset last
    logic [7:0] ra [5] = '{OFS_FLOW_VAR, OFS_SOFT_RST, OFS_THERM,
                           OFS_T_RESULT, 8'h55};
    logic [7:0] rv [5] = '{RST_FLOW_VAR, SOFT_RST_READ, 8'h00,
                           RST_T_RESULT, READ_ZERO};
    always #50 clock_i = ~clock_i;
    aotc_sensor_model u_sens (.clock_i(clock_i), .enable_i(sensor_enable_o),
        .level_i(lvl), .value_o(sensor_value_i));
    aotc_ctrl #(.CONV_CNT(20)) DUT (.clock_i(clock_i), .rstn_i(rstn_i),
        .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .irq_event_i(irq_event_i), .power_save_i(power_save_i),
        .sensor_value_i(sensor_value_i), .sensor_enable_o(sensor_enable_o),
        .aux_output_pin_o(aux_o), .irq_pin_o(irq_o), .irq_pin_oe_o(oe_o),
        .program_flow_variable_o(flow_o), .compensation_temp_o(comp_o),
        .soft_reset_o(srst_o));
    // expected thermal register: busy flag over the control bits
    function automatic logic [7:0] therm(input logic b, input logic [2:0] f);
        return {b, 4'h0, f};
    endfunction : therm
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one register access, read data left in q
    task automatic acc(input logic w, input logic [7:0] a, d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge clock_i);
        reg_wr_i <= 1'h0;
        reg_rd_i <= 1'h0;
        @(posedge clock_i);
        q = reg_rdata_o;
    endtask : acc
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask : idle
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h1E1B484B));
        idle(2);
        rstn_i <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            acc(1'h0, ra[i], 8'h00);
            chk(q, rv[i]);
        end
        // every role and level combination of the pin control
        for (int i = 0; i < 8; i++) begin
            acc(1'h1, OFS_PIN_CTRL, 8'(i));
            chk({6'h0, aux_o, oe_o}, {6'h0, i[1], i[2]});
            chk({7'h0, irq_o}, {7'h0, i[2] & i[0]});
            acc(1'h0, OFS_PIN_CTRL, 8'h00);
            chk({5'h0, q[2:0]}, 8'(i));
        end
        // interrupt role: event pulls the pin, status read frees it
        acc(1'h1, OFS_PIN_CTRL, 8'h00);
        irq_event_i <= 1'h1;
        idle(1);
        irq_event_i <= 1'h0;
        idle(1);
        chk({7'h0, oe_o}, 8'h01);
        acc(1'h0, OFS_STATUS, 8'h00);
        chk({7'h0, oe_o}, 8'h00);
        // flow variable, ignored and real soft reset
        v = 8'($urandom());
        acc(1'h1, OFS_FLOW_VAR, v);
        chk(flow_o, v);
        // clock enable low: the write is frozen out
        ce_i <= 1'h0;
        acc(1'h1, OFS_FLOW_VAR, ~v);
        chk(flow_o, v);
        ce_i <= 1'h1;
        acc(1'h1, OFS_SOFT_RST, {1'h0, v[6:0]});
        acc(1'h0, OFS_SOFT_RST, 8'h00);
        chk(q, SOFT_RST_READ);
        chk(flow_o, v);
        acc(1'h1, OFS_PIN_CTRL, 8'h02);
        acc(1'h1, OFS_SOFT_RST, SOFT_RST_KEY);
        idle(1);
        chk(flow_o, RST_FLOW_VAR);
        chk({7'h0, aux_o}, 8'h00);
        // restart in mid-conversion, then busy length and result
        lvl <= 8'($urandom());
        acc(1'h1, OFS_THERM, 8'h04);
        idle(10);
        acc(1'h1, OFS_THERM, 8'h04);
        idle(16);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h1, 3'h4));
        idle(1);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h0, 3'h4));
        acc(1'h0, OFS_T_RESULT, 8'h00);
        chk(q, lvl);
        chk(comp_o, lvl);
        v = 8'($urandom());
        acc(1'h1, OFS_T_EXT, v);
        acc(1'h1, OFS_THERM, 8'h05);
        chk(comp_o, v);
        // repeat mode: needs enable, runs on, pauses in power save
        acc(1'h1, OFS_THERM, 8'h02);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h0, 3'h2));
        acc(1'h0, OFS_T_RESULT, 8'h00);
        chk(q, lvl);
        acc(1'h1, OFS_THERM, 8'h06);
        idle(30);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h1, 3'h6));
        power_save_i <= 1'h1;
        idle(3);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h0, 3'h6));
        power_save_i <= 1'h0;
        idle(3);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h1, 3'h6));
        // hardware reset in mid-run, with a conversion going
        acc(1'h1, OFS_FLOW_VAR, v);
        rstn_i <= 1'h0;
        idle(2);
        rstn_i <= 1'h1;
        idle(1);
        chk(flow_o, RST_FLOW_VAR);
        chk(comp_o, RST_T_RESULT);
        acc(1'h0, OFS_THERM, 8'h00);
        chk(q, therm(1'h0, 3'h0));
        complete_run();
    end
endmodule : testbench
`default_nettype wire
